/* core/scst_defs.vh */
/*
   constants for the card status-bit tracker: bit positions of the status
   word, response kinds, register offsets, reset values and clear classes.
   assumes it is included by bare name from the tracker module.
*/
`ifndef SCST_DEFS_VH
`define SCST_DEFS_VH

// status word positions, 15:8 first byte, 7:0 second byte
`define SCST_B_IDLE        8
`define SCST_B_ERASE_RST   9
`define SCST_B_ILLEGAL     10
`define SCST_B_CRC         11
`define SCST_B_ERASE_SEQ   12
`define SCST_B_ADDR        13
`define SCST_B_PARAM       14
`define SCST_B_LOCKED      0
`define SCST_B_SKIP_LOCK   1
`define SCST_B_ERROR       2
`define SCST_B_CC          3
`define SCST_B_ECC         4
`define SCST_B_WP          5
`define SCST_B_ERASE_PARAM 6
`define SCST_B_RANGE       7
`define SCST_NBITS         16

// bits that clear on read (all but locked and idle)
`define SCST_CLR_READ      16'h7E_FE
// error bits taken into the data error token, low four bits
`define SCST_TOKEN_MASK    8'h0F

// register offsets
`define SCST_A_EVENT       12'h000
`define SCST_A_STATE       12'h004
`define SCST_A_STATUS      12'h008
`define SCST_A_CONTROL     12'h00C
`define SCST_A_RELADDR     12'h010
`define SCST_RESET_STATUS  16'h01_00
`define SCST_RESET_CTRL    32'h0000_0000

// control fields
`define SCST_C_LOCK        0
`define SCST_C_INIT_DONE   1
`define SCST_C_RESET_CMD   2

// response kinds
`define SCST_K_R1          2'd0
`define SCST_K_R2          2'd1
`define SCST_K_TOKEN       2'd2

`endif

/* core/scst_status_tracker.v */
/*
   status-bit tracker of a serial-mode memory card: holds the card status
   flags, shifts the one-byte, two-byte and data-error-token formats out
   msb first on the serial link and clears flags after they are read.
   assumes an apb master on clk_sys and a host that drives the serial
   clock; the serial clock and start request arrive asynchronously.
*/
`timescale 1ns/10ps
`include "scst_defs.vh"

module scst_status_tracker #(
   parameter NBITS = `SCST_NBITS
) (
   // clock and reset
   input  wire        clk_sys,
   input  wire        rst,
   // apb slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // serial link from host
   input  wire        linkClk,
   input  wire        respStart,
   input  wire [1:0]  respKind,
   // serial link to host
   output reg         respData,
   output reg         respBusy
);

   localparam ST_IDLE = 2'd0;
   localparam ST_SHIFT = 2'd1;
   localparam ST_DONE = 2'd2;

   reg [NBITS-1:0] status_reg;
   reg [NBITS-1:0] status_next;
   reg [31:0]      control_reg;
   reg [2:0]       clkSync_reg;
   reg [2:0]       startSync_reg;
   reg [1:0]       kindSync1_reg;
   reg [1:0]       kindSync2_reg;
   reg [1:0]       state_reg;
   reg [15:0]      shift_reg;
   reg [4:0]       bitCnt_reg;
   reg [1:0]       kind_reg;
   reg [NBITS-1:0] readMask_reg;
   reg [NBITS-1:0] clearPulse_reg;
   reg [NBITS-1:0] eventSet;
   reg [15:0]      loadWord;
   reg [4:0]       loadBits;

   wire linkFall = clkSync_reg[2] & ~clkSync_reg[1];
   wire startRise = startSync_reg[1] & ~startSync_reg[2];
   wire apbAccess = psel & penable & pready;
   wire apbWrite = apbAccess & pwrite;

   // two-flop synchronisers, third stage feeds edge detection
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         clkSync_reg   <= 3'b000;
         startSync_reg <= 3'b000;
         kindSync1_reg <= 2'b00;
         kindSync2_reg <= 2'b00;
      end else begin
         clkSync_reg   <= {clkSync_reg[1:0], linkClk};
         startSync_reg <= {startSync_reg[1:0], respStart};
         kindSync1_reg <= respKind;
         kindSync2_reg <= kindSync1_reg;
      end
   end

   // events written by the card logic through the event register
   always @* begin
      eventSet = {NBITS{1'b0}};
      if (apbWrite && paddr == `SCST_A_EVENT) begin
         eventSet = pwdata[NBITS-1:0];
      end
   end

   // per-bit flag update; a set arriving with a clear wins
   genvar i;
   generate
      for (i = 0; i < NBITS; i = i + 1) begin : g_flag
         always @* begin
            if (i == `SCST_B_LOCKED) begin
               status_next[i] = control_reg[`SCST_C_LOCK];
            end else if (i == `SCST_B_IDLE) begin
               if (control_reg[`SCST_C_INIT_DONE]) begin
                  status_next[i] = 1'b0;
               end else begin
                  status_next[i] = status_reg[i];
               end
            end else if (eventSet[i]) begin
               status_next[i] = 1'b1;
            end else if (clearPulse_reg[i]) begin
               status_next[i] = 1'b0;
            end else begin
               status_next[i] = status_reg[i];
            end
         end
      end
   endgenerate

   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         status_reg <= `SCST_RESET_STATUS;
      end else if (apbWrite && paddr == `SCST_A_CONTROL && pwdata[`SCST_C_RESET_CMD]) begin
         status_reg <= `SCST_RESET_STATUS;
      end else begin
         status_reg <= status_next;
      end
   end

   // response word, left aligned, for each format
   always @* begin
      loadWord = {1'b0, status_reg[14:8], 8'h00};
      loadBits = 5'd8;
      case (kindSync2_reg)
         `SCST_K_R1: begin
            loadWord = {1'b0, status_reg[14:8], 8'h00};
            loadBits = 5'd8;
         end
         `SCST_K_R2: begin
            loadWord = {1'b0, status_reg[14:0]};
            loadBits = 5'd16;
         end
         `SCST_K_TOKEN: begin
            loadWord = {4'h0, status_reg[3:0], 8'h00};
            loadBits = 5'd8;
         end
         default: begin
            loadWord = {1'b0, status_reg[14:8], 8'h00};
            loadBits = 5'd8;
         end
      endcase
   end

   // serial shifter: new bit after each falling edge of the link clock
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state_reg      <= ST_IDLE;
         shift_reg      <= 16'h0000;
         bitCnt_reg     <= 5'd0;
         kind_reg       <= 2'b00;
         readMask_reg   <= {NBITS{1'b0}};
         clearPulse_reg <= {NBITS{1'b0}};
         respData       <= 1'b0;
         respBusy       <= 1'b0;
      end else begin
         clearPulse_reg <= {NBITS{1'b0}};
         case (state_reg)
            ST_IDLE: begin
               if (startRise) begin
                  shift_reg  <= loadWord;
                  bitCnt_reg <= loadBits;
                  kind_reg   <= kindSync2_reg;
                  respData   <= loadWord[15];
                  respBusy   <= 1'b1;
                  // snapshot which flags were reported
                  if (kindSync2_reg == `SCST_K_R2) begin
                     readMask_reg <= status_reg & `SCST_CLR_READ;
                  end else if (kindSync2_reg == `SCST_K_TOKEN) begin
                     readMask_reg <= status_reg & 16'h00_0F;
                  end else begin
                     readMask_reg <= status_reg & 16'h7E_00;
                  end
                  state_reg <= ST_SHIFT;
               end
            end
            ST_SHIFT: begin
               if (linkFall) begin
                  shift_reg  <= {shift_reg[14:0], 1'b0};
                  bitCnt_reg <= bitCnt_reg - 5'd1;
                  respData   <= shift_reg[14];
                  if (bitCnt_reg == 5'd1) begin
                     state_reg <= ST_DONE;
                  end
               end
            end
            ST_DONE: begin
               clearPulse_reg <= readMask_reg;
               respBusy       <= 1'b0;
               respData       <= 1'b0;
               state_reg      <= ST_IDLE;
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   // apb slave, one wait state
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         control_reg <= `SCST_RESET_CTRL;
         prdata      <= 32'h0000_0000;
         pready      <= 1'b0;
         pslverr     <= 1'b0;
      end else begin
         pready  <= psel & penable & ~pready;
         pslverr <= 1'b0;
         if (psel && penable && !pready) begin
            prdata <= 32'h0000_0000;
            case (paddr)
               `SCST_A_EVENT: prdata <= 32'h0000_0000;
               `SCST_A_STATE: prdata <= {16'h0000, status_reg};
               `SCST_A_STATUS: prdata <= {27'h0000_000, state_reg, bitCnt_reg[1:0], respBusy};
               `SCST_A_CONTROL: prdata <= control_reg;
               `SCST_A_RELADDR: pslverr <= 1'b1;
               default: pslverr <= 1'b1;
            endcase
         end
         if (apbWrite && paddr == `SCST_A_CONTROL) begin
            control_reg <= {29'h0000_000, 1'b0, pwdata[1:0]};
         end
      end
   end

endmodule

/* testbench/scst_status_tracker_properties.sv */
/* port checker for the status-bit tracker.
   assumes it is bound onto scst_status_tracker. */
`timescale 1ns/10ps
module scst_status_tracker_properties #(
   parameter NBITS = 16
) (
   // clock and reset
   input logic        clk_sys, rst,
   // apb
   input logic        psel, penable, pwrite, pready, pslverr,
   input logic [11:0] paddr,
   input logic [31:0] pwdata, prdata,
   // serial link
   input logic        linkClk, respStart, respData, respBusy,
   input logic [1:0]  respKind
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   reladdr_deny_a: assert property ($rose(penable) && psel && paddr == 12'h010 |=> pslverr)
      else $error("address register not refused");
   mapped_ok_a: assert property ($rose(penable) && psel && paddr < 12'h010 |=> pready && !pslverr)
      else $error("mapped access refused");
   err_ready_a: assert property (pslverr |-> pready)
      else $error("error without ready");
   msb_zero_a: assert property ($rose(respBusy) |-> !respData)
      else $error("first bit not zero");
   start_busy_a: assert property ($rose(respStart) && !respBusy |-> ##[1:8] respBusy)
      else $error("response not started");
   bit_hold_a: assert property ($rose(linkClk) && respBusy |=> $stable(respData) [*6])
      else $error("bit changed while clock high");
   end_low_a: assert property ($fell(respBusy) |-> !linkClk)
      else $error("ended before last bit");
   reset_quiet_a: assert property ($fell(rst) |-> !respBusy && !pready && !respData)
      else $error("outputs active after reset");
endmodule

bind scst_status_tracker scst_status_tracker_properties #(.NBITS(NBITS)) chk (
   .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
   .pready(pready), .pslverr(pslverr), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .linkClk(linkClk), .respStart(respStart), .respData(respData), .respBusy(respBusy),
   .respKind(respKind));

/* testbench/scst_host_model.sv */
/* host side of the serial status link: clocks frames and collects bits.
   assumes the tracker answers on respBusy and respData. */
`timescale 1ns/10ps
module scst_host_model (
   // link to the card
   output logic       linkClk,
   output logic       respStart,
   output logic [1:0] respKind,
   // link from the card
   input  logic       respData,
   input  logic       respBusy
);
   initial begin
      linkClk = 1'b0;
      respStart = 1'b0;
      respKind = 2'd0;
   end
   // one frame of nb bits, msb first; clock stands low between frames
   task automatic frame(input logic [1:0] k, input int nb, output logic [15:0] got);
      int n;
      got = 16'h0000;
      respKind = k;
      #9 respStart = 1'b1;
      n = 0;
      while (respBusy !== 1'b1 && n < 100) begin
         #4 n++;
      end
      for (int i = 0; i < nb; i++) begin
         #32 linkClk = 1'b1;
         got = {got[14:0], respData};
         #32 linkClk = 1'b0;
      end
      n = 0;
      while (respBusy !== 1'b0 && n < 100) begin
         #4 n++;
      end
      respStart = 1'b0;
      #40;
   endtask
endmodule

/* testbench/tb_top.sv */
/* self-checking bench for the status-bit tracker.
   assumes the port checker is bound onto the tracker. */
`timescale 1ns/10ps
module tb_top;
   logic        clk_sys, rst, psel, penable, pwrite, pready, pslverr;
   logic        linkClk, respStart, respData, respBusy;
   logic [1:0]  respKind;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [15:0] got;
   int          n_errors = 0;
   int          total_checks = 0;

   scst_status_tracker uut (
      .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .linkClk(linkClk), .respStart(respStart), .respKind(respKind), .respData(respData),
      .respBusy(respBusy));
   scst_host_model host (
      .linkClk(linkClk), .respStart(respStart), .respKind(respKind), .respData(respData),
      .respBusy(respBusy));

   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] want);
      total_checks++;
      if (seen !== want) begin
         $display("unexpected at %0t: seen %h want %h", $time, seen, want);
         n_errors++;
      end
   endtask

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   // one apb transfer, held until pready under a bound
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      int n;
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      n = 0;
      do begin
         @(negedge clk_sys);
         n++;
      end while (pready !== 1'b1 && n < 50);
      r = prdata;
      e = pslverr;
      @(posedge clk_sys);
      if (n >= 50) n_errors++;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
   endtask

   // data is compared only where no error response is expected
   task automatic rd(input logic [11:0] a, input logic [15:0] want, input logic err);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0000_0000, r, e);
      if (!err) chk({16'h0000, r[15:0]}, {16'h0000, want});
      chk({31'h0000_0000, e}, {31'h0000_0000, err});
   endtask

   task automatic fr(input logic [1:0] k, input int nb, input logic [15:0] want);
      host.frame(k, nb, got);
      chk({16'h0000, got}, {16'h0000, want});
   endtask

   task automatic t_reset;
      rd(12'h004, 16'h0100, 1'b0);
      rd(12'h010, 16'h0000, 1'b1);
      rd(12'h020, 16'h0000, 1'b1);
      $display("reset test done");
   endtask

   task automatic t_one_byte;
      wr(12'h000, 32'h0000_7EF0);
      fr(2'd0, 8, 16'h007F);
      rd(12'h004, 16'h01F0, 1'b0);
      $display("one-byte test done");
   endtask

   task automatic t_two_byte;
      wr(12'h000, 32'h0000_00FE);
      wr(12'h00C, 32'h0000_0001);
      fr(2'd1, 16, 16'h01FF);
      rd(12'h004, 16'h0101, 1'b0);
      wr(12'h00C, 32'h0000_0000);
      rd(12'h004, 16'h0100, 1'b0);
      $display("two-byte test done");
   endtask

   task automatic t_token;
      wr(12'h000, 32'h0000_40F6);
      fr(2'd2, 8, 16'h0006);
      rd(12'h004, 16'h41F0, 1'b0);
      $display("token test done");
   endtask

   task automatic t_init;
      wr(12'h00C, 32'h0000_0002);
      rd(12'h004, 16'h40F0, 1'b0);
      wr(12'h004, 32'h0000_FFFF);
      rd(12'h004, 16'h40F0, 1'b0);
      wr(12'h00C, 32'h0000_0004);
      rd(12'h004, 16'h0100, 1'b0);
      rd(12'h00C, 16'h0000, 1'b0);
      $display("init test done");
   endtask

   initial begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      repeat (8) @(posedge clk_sys);
      rst <= 1'b0;
      t_reset;
      t_one_byte;
      t_two_byte;
      t_token;
      t_init;
      give_verdict;
   end

   // cuts a hang short
   initial begin
      #100000;
      n_errors++;
      give_verdict;
   end
endmodule
